// ===== design/tpx_map.vh
// timing counts and behaviour notes for the twisted-pair control block
// assumes a 250 MHz core clock; the 10 MHz oscillator tick is derived inside the block
// Notes on behaviour
// - receive enable on squelch accept or loopback
// - receive data held high while disabled
// - loopback routes tx data, driver sends link
// - link fail output high while link failed
// - link fail toggles every 100 ms receiving
// - jabber output high during jabber condition
// - collision output high on jabber or collision
// - collision output high briefly during selftest
// - duplex select low means full duplex
// - selftest exercises collision, line untouched
// - two transmit inputs merged into one stream
// - first falling edge starts driver quickly
// - pre-emphasis about 50 ns per transition
// - frame during link pulse keeps driver on
// - transmit beyond 20 ms enters jabber
// - jabber ends on enable low or 500 ms quiet
// - idle link pulse 100 ns every 16 ms
// - no normal loopback in collision or full duplex
// - unsquelch with transmit enable is collision
`ifndef TPX_MAP_VH
`define TPX_MAP_VH

// ----------------------------------------------------------------
// clock rates and derived cycle counts
// ----------------------------------------------------------------
`define TPX_CLK_MHZ         250
`define TPX_OSC_MHZ         10
`define TPX_OSC_DIV         (`TPX_CLK_MHZ / `TPX_OSC_MHZ)
`define TPX_PREEMPH_NS      50
`define TPX_PREEMPH_CYC     ((`TPX_PREEMPH_NS * `TPX_CLK_MHZ) / 1000)
`define TPX_LINKPW_NS       100
`define TPX_LINKPW_TICKS    ((`TPX_LINKPW_NS * `TPX_OSC_MHZ) / 1000)
`define TPX_IDLE_NS         250
`define TPX_IDLE_CYC        ((`TPX_IDLE_NS * `TPX_CLK_MHZ) / 1000)
`define TPX_SQE_NS          1000
`define TPX_SQE_TICKS       ((`TPX_SQE_NS * `TPX_OSC_MHZ) / 1000)

// ----------------------------------------------------------------
// long intervals in oscillator ticks (ms * 10000)
// ----------------------------------------------------------------
`define TPX_JAB_MS          20
`define TPX_JAB_TICKS       (`TPX_JAB_MS * 1000 * `TPX_OSC_MHZ)
`define TPX_UNJAB_MS        500
`define TPX_UNJAB_TICKS     (`TPX_UNJAB_MS * 1000 * `TPX_OSC_MHZ)
`define TPX_LINKINT_MS      16
`define TPX_LINKINT_TICKS   (`TPX_LINKINT_MS * 1000 * `TPX_OSC_MHZ)
`define TPX_BLINK_MS        100
`define TPX_BLINK_TICKS     (`TPX_BLINK_MS * 1000 * `TPX_OSC_MHZ)

`endif

// ===== design/tpx_skid.v
// two-entry buffer for the received data stream
// assumes one clock; drain side may stall by lowering out_ready
`timescale 1ns/10ps
module tpx_skid #(
	parameter WIDTH = 2
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	reg [WIDTH-1:0] mem_r [0:1];
	reg             wp_r;
	reg             rp_r;
	reg [1:0]       cnt_r;
	wire            push;
	wire            pop;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// pointers and fill count
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push)
				wp_r <= ~wp_r;
			if (pop)
				rp_r <= ~rp_r;
			if (push & ~pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 2'h1;
		end
	end

	// data write, no reset needed
	always @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end
endmodule

// ===== design/tpx_ctrl.v
// control logic of a twisted-pair transceiver: transmit, link pulses, jabber,
// loopback, receive gating and status outputs
// assumes squelch qualification and line drive are done outside; pins are async
`timescale 1ns/10ps
`include "tpx_map.vh"
module tpx_ctrl #(
	parameter JAB_TICKS     = `TPX_JAB_TICKS,
	parameter UNJAB_TICKS   = `TPX_UNJAB_TICKS,
	parameter LINKINT_TICKS = `TPX_LINKINT_TICKS,
	parameter BLINK_TICKS   = `TPX_BLINK_TICKS
) (
	input  wire clk,
	input  wire resetn,
	input  wire tx_data_a,
	input  wire tx_data_b,
	input  wire tx_enable,
	input  wire loopback_n,
	input  wire full_duplex_select_n,
	input  wire collision_selftest_n,
	input  wire rx_unsquelched,
	input  wire rx_line_data,
	input  wire link_failed,
	input  wire rx_out_ready,
	output reg  rx_enable,
	output reg  rx_data_a,
	output reg  rx_data_b,
	output reg  tx_drive_en,
	output reg  tx_line_data,
	output reg  tx_preemph,
	output reg  link_fail_status,
	output reg  jabber_status,
	output reg  collision_or_jabber_status,
	output reg  osc_resync
);
	// ----------------------------------------------------------------
	// input synchronisers: three stages, change taken when 2 and 3 agree
	// ----------------------------------------------------------------
	localparam NIN = 9;
	// interval ends held at 32 bits, cut to each counter width where used
	localparam [31:0] OSC_END_W   = `TPX_OSC_DIV - 1;
	localparam [31:0] LINK_END_W  = LINKINT_TICKS - 1;
	localparam [31:0] LPW_END_W   = `TPX_LINKPW_TICKS - 1;
	localparam [31:0] JAB_END_W   = JAB_TICKS - 1;
	localparam [31:0] IDLE_END_W  = `TPX_IDLE_CYC - 1;
	localparam [31:0] UNJAB_END_W = UNJAB_TICKS - 1;
	localparam [31:0] PRE_LEN_W   = `TPX_PREEMPH_CYC;
	localparam [31:0] SQE_LEN_W   = `TPX_SQE_TICKS;
	localparam [31:0] BLINK_END_W = BLINK_TICKS - 1;
	wire [NIN-1:0] pin_raw;
	reg  [NIN-1:0] s1_r;
	reg  [NIN-1:0] s2_r;
	reg  [NIN-1:0] s3_r;
	reg  [NIN-1:0] pin_r;
	reg  [2:0]     rst_cnt_r;
	reg            rst_hold_r;

	assign pin_raw = {tx_data_a, tx_data_b, tx_enable, loopback_n, full_duplex_select_n,
		collision_selftest_n, rx_unsquelched, rx_line_data, link_failed};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
			// all stages preset high; tx enable, unsquelch and link fail masked low by the reset hold
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1_r[gi]  <= 1'b1;
					s2_r[gi]  <= 1'b1;
					s3_r[gi]  <= 1'b1;
					pin_r[gi] <= 1'b1;
				end else begin
					s1_r[gi] <= pin_raw[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi])
						pin_r[gi] <= s3_r[gi];
				end
			end
		end
	endgenerate

	wire txa   = pin_r[8];
	wire txb   = pin_r[7];
	wire lpbn  = pin_r[5];
	wire fdn   = pin_r[4];
	wire sqen  = pin_r[3];
	wire unsq  = pin_r[2] & ~rst_hold_r;
	wire rxd   = pin_r[1];
	wire lfail = pin_r[0] & ~rst_hold_r;

	// ----------------------------------------------------------------
	// reset hold: tx enable, unsquelch and link fail masked low until the pipe has filled
	// ----------------------------------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_cnt_r  <= 3'h0;
			rst_hold_r <= 1'b1;
		end else if (rst_cnt_r != 3'h7) begin
			rst_cnt_r <= rst_cnt_r + 3'h1;
		end else begin
			rst_hold_r <= 1'b0;
		end
	end
	wire txen_q = pin_r[6] & ~rst_hold_r;

	// ----------------------------------------------------------------
	// 10 MHz oscillator tick; resynchronised on frame start
	// ----------------------------------------------------------------
	reg  [4:0] div_r;
	reg        tick_r;
	wire       resync;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r  <= 5'h00;
			tick_r <= 1'b0;
		end else if (resync || div_r == OSC_END_W[4:0]) begin
			div_r  <= 5'h00;
			tick_r <= ~resync;
		end else begin
			div_r  <= div_r + 5'h01;
			tick_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// merged transmit stream and edge detect
	// ----------------------------------------------------------------
	wire tx_merged = txa & txb; // unused input idles high
	reg  tx_prev_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			tx_prev_r <= 1'b1;
		else
			tx_prev_r <= tx_merged;
	end
	wire tx_edge = tx_merged ^ tx_prev_r;
	wire tx_fall = tx_prev_r & ~tx_merged;

	// ----------------------------------------------------------------
	// driver state machine
	// ----------------------------------------------------------------
	reg  [1:0]  st_r;
	reg  [7:0]  idle_cnt_r;
	reg  [27:0] jab_cnt_r;
	reg  [27:0] quiet_cnt_r;
	reg  [27:0] link_cnt_r;
	reg  [3:0]  lpw_cnt_r;
	reg  [3:0]  pre_cnt_r;
	// driver states, binary coded
	localparam [1:0] DRV_IDLE = 2'h0;
	localparam [1:0] DRV_DATA = 2'h1;
	localparam [1:0] DRV_LINK = 2'h2;
	localparam [1:0] DRV_JAB  = 2'h3;
	wire        frame_start = tx_fall & txen_q & (st_r != DRV_JAB);

	assign resync = frame_start & (st_r != DRV_DATA);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r        <= DRV_IDLE;
			idle_cnt_r  <= 8'h00;
			jab_cnt_r   <= 28'h0;
			quiet_cnt_r <= 28'h0;
			link_cnt_r  <= 28'h0;
			lpw_cnt_r   <= 4'h0;
		end else begin
			case (st_r)
				DRV_IDLE: begin
					if (frame_start) begin
						st_r       <= DRV_DATA;
						idle_cnt_r <= 8'h00;
						jab_cnt_r  <= 28'h0;
					end else if (tick_r) begin
						if (link_cnt_r == LINK_END_W[27:0]) begin
							link_cnt_r <= 28'h0;
							lpw_cnt_r  <= 4'h0;
							st_r       <= DRV_LINK;
						end else begin
							link_cnt_r <= link_cnt_r + 28'h1;
						end
					end
				end
				DRV_LINK: begin
					if (frame_start) begin
						st_r       <= DRV_DATA;
						idle_cnt_r <= 8'h00;
						jab_cnt_r  <= 28'h0;
					end else if (tick_r) begin
						if (lpw_cnt_r == LPW_END_W[3:0])
							st_r <= DRV_IDLE;
						else
							lpw_cnt_r <= lpw_cnt_r + 4'h1;
					end
				end
				DRV_DATA: begin
					link_cnt_r <= 28'h0;
					if (tick_r)
						jab_cnt_r <= jab_cnt_r + 28'h1;
					if (tick_r && jab_cnt_r == JAB_END_W[27:0]) begin
						st_r        <= DRV_JAB;
						quiet_cnt_r <= 28'h0;
					end else if (tx_edge && txen_q) begin
						idle_cnt_r <= 8'h00;
					end else if (idle_cnt_r == IDLE_END_W[7:0]) begin
						st_r <= DRV_IDLE;
					end else begin
						idle_cnt_r <= idle_cnt_r + 8'h01;
					end
				end
				DRV_JAB: begin
					if (tx_edge)
						quiet_cnt_r <= 28'h0;
					else if (tick_r)
						quiet_cnt_r <= quiet_cnt_r + 28'h1;
					if (!txen_q || (tick_r && quiet_cnt_r == UNJAB_END_W[27:0]))
						st_r <= DRV_IDLE;
				end
				default: st_r <= DRV_IDLE;
			endcase
		end
	end

	// pre-emphasis counter restarted on each transmitted transition
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			pre_cnt_r <= 4'h0;
		else if (tx_edge && (st_r == DRV_DATA || frame_start) && lpbn)
			pre_cnt_r <= PRE_LEN_W[3:0];
		else if (pre_cnt_r != 4'h0)
			pre_cnt_r <= pre_cnt_r - 4'h1;
	end

	// ----------------------------------------------------------------
	// collision, selftest pulse
	// ----------------------------------------------------------------
	reg       coll_r;
	reg       sqe_prev_r;
	reg [3:0] sqe_cnt_r;
	wire      full_dup = ~fdn;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			coll_r     <= 1'b0;
			sqe_prev_r <= 1'b1;
			sqe_cnt_r  <= 4'h0;
		end else begin
			coll_r     <= unsq & txen_q & ~full_dup;
			sqe_prev_r <= sqen;
			if (sqe_prev_r && !sqen)
				sqe_cnt_r <= SQE_LEN_W[3:0];
			else if (tick_r && sqe_cnt_r != 4'h0)
				sqe_cnt_r <= sqe_cnt_r - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// receive path: loopback selection through the two-entry buffer
	// ----------------------------------------------------------------
	wire       lpb_test   = ~lpbn;
	wire       lpb_normal = lpbn & txen_q & ~coll_r & ~full_dup & ~unsq;
	wire       lpb_act    = lpb_test & txen_q | lpb_normal;
	wire       rx_en_nxt  = (unsq & lpbn) | lpb_act;
	wire       rx_src     = lpb_act ? tx_merged : rxd;
	wire [1:0] buf_out;
	wire       buf_valid;
	wire       buf_in_ready;

	tpx_skid #(
		.WIDTH (2)
	) u_skid (
		.clk       (clk),
		.resetn    (resetn),
		.in_valid  (1'b1),
		.in_ready  (buf_in_ready),
		.in_data   ({rx_en_nxt, rx_src}),
		.out_valid (buf_valid),
		.out_ready (rx_out_ready),
		.out_data  (buf_out)
	);

	// ----------------------------------------------------------------
	// link-fail blink while receiving
	// ----------------------------------------------------------------
	reg [27:0] blink_cnt_r;
	reg        blink_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blink_cnt_r <= 28'h0;
			blink_r     <= 1'b0;
		end else if (!unsq) begin
			blink_cnt_r <= 28'h0;
			blink_r     <= 1'b0;
		end else if (tick_r) begin
			if (blink_cnt_r == BLINK_END_W[27:0]) begin
				blink_cnt_r <= 28'h0;
				blink_r     <= ~blink_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 28'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	wire rx_en_b = buf_valid & buf_out[1];
	wire jab     = (st_r == DRV_JAB);
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_enable                  <= 1'b0;
			rx_data_a                  <= 1'b1;
			rx_data_b                  <= 1'b1;
			tx_drive_en                <= 1'b0;
			tx_line_data               <= 1'b1;
			tx_preemph                 <= 1'b0;
			link_fail_status           <= 1'b0;
			jabber_status              <= 1'b0;
			collision_or_jabber_status <= 1'b0;
			osc_resync                 <= 1'b0;
		end else begin
			rx_enable  <= rx_en_b;
			rx_data_a  <= rx_en_b ? buf_out[0] : 1'b1;
			rx_data_b  <= rx_en_b ? buf_out[0] : 1'b1;
			// loopback test sends only link pulses; jabber silences driver
			tx_drive_en  <= (st_r == DRV_LINK) |
				((st_r == DRV_DATA) & lpbn);
			tx_line_data <= (st_r == DRV_LINK) ? 1'b1 : tx_merged;
			tx_preemph   <= (pre_cnt_r != 4'h0) & (st_r == DRV_DATA);
			link_fail_status <= unsq ? blink_r : lfail;
			jabber_status    <= jab;
			collision_or_jabber_status <= jab | coll_r | (sqe_cnt_r != 4'h0);
			osc_resync <= resync;
		end
	end
endmodule

// ===== bench/tpx_monitor.sv
// checker of port relations of tpx_ctrl
// assumes it is bound to tpx_ctrl; one clock domain
`timescale 1ns/10ps
module tpx_monitor (
	input wire clk,
	input wire resetn,
	input wire tx_enable,
	input wire loopback_n,
	input wire full_duplex_select_n,
	input wire collision_selftest_n,
	input wire rx_unsquelched,
	input wire link_failed,
	input wire rx_enable,
	input wire rx_data_a,
	input wire rx_data_b,
	input wire tx_drive_en,
	input wire tx_preemph,
	input wire link_fail_status,
	input wire jabber_status,
	input wire collision_or_jabber_status,
	input wire osc_resync
);
	// ------
	// run lengths of conditions
	// ------
	reg [7:0] pe_r;
	reg [7:0] lf_r;
	reg [7:0] rx_r;
	reg [7:0] co_r;
	function [7:0] sat(input [7:0] v);
		sat = (v == 8'hFF) ? v : v + 8'h01;
	endfunction
	// saturating counters, cleared when the condition drops
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pe_r <= 8'h00;
			lf_r <= 8'h00;
			rx_r <= 8'h00;
			co_r <= 8'h00;
		end else begin
			pe_r <= tx_preemph ? sat(pe_r) : 8'h00;
			lf_r <= (link_failed && !rx_unsquelched) ? sat(lf_r) : 8'h00;
			rx_r <= (rx_unsquelched && !tx_enable && loopback_n) ? sat(rx_r) : 8'h00;
			co_r <= (tx_enable && rx_unsquelched && full_duplex_select_n) ? sat(co_r) : 8'h00;
		end
	end
	// ------
	// assertions
	// ------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_pulse;
		osc_resync ##1 !osc_resync;
	endsequence
	sequence s_start;
		osc_resync ##[1:2] tx_drive_en;
	endsequence
	chk_rxd_held_high: assert property (!rx_enable |-> rx_data_a && rx_data_b)
		else $error("rx data not high while rx disabled");
	chk_preemph_len: assert property (pe_r <= 8'h0C)
		else $error("preemphasis longer than 12 cycles");
	chk_resync_pulse: assert property (osc_resync |-> s_pulse)
		else $error("resync pulse not one cycle");
	chk_resync_drive: assert property (osc_resync && loopback_n && !jabber_status |-> s_start)
		else $error("driver not on after frame start");
	chk_jab_sets_col: assert property (jabber_status |-> collision_or_jabber_status)
		else $error("jabber without collision status");
	chk_jab_no_drive: assert property (jabber_status && $past(jabber_status) |-> !tx_drive_en)
		else $error("driver on during jabber");
	chk_link_fail_on: assert property (lf_r >= 8'h14 |-> link_fail_status)
		else $error("link fail status low while link failed");
	chk_rx_en_on: assert property (rx_r >= 8'h14 |-> rx_enable)
		else $error("rx enable low while unsquelched");
	chk_col_flag_on: assert property (co_r >= 8'h14 |-> collision_or_jabber_status)
		else $error("collision not flagged");
	chk_selftest_col: assert property ($fell(collision_selftest_n) |-> ##[2:20] collision_or_jabber_status)
		else $error("selftest pulse missing");
endmodule
bind tpx_ctrl tpx_monitor u_mon (.clk(clk), .resetn(resetn), .tx_enable(tx_enable),
	.loopback_n(loopback_n), .full_duplex_select_n(full_duplex_select_n),
	.collision_selftest_n(collision_selftest_n), .rx_unsquelched(rx_unsquelched),
	.link_failed(link_failed), .rx_enable(rx_enable), .rx_data_a(rx_data_a),
	.rx_data_b(rx_data_b), .tx_drive_en(tx_drive_en), .tx_preemph(tx_preemph),
	.link_fail_status(link_fail_status), .jabber_status(jabber_status),
	.collision_or_jabber_status(collision_or_jabber_status), .osc_resync(osc_resync));

// ===== bench/tpx_far.sv
// far-side transmit source: enable, then toggling data on one input
// assumes one clock; hold keeps enable high with data frozen
`timescale 1ns/10ps
module tpx_far #(
	parameter HALF = 16
) (
	input  wire clk,
	input  wire resetn,
	input  wire run,
	input  wire hold,
	input  wire use_b,
	output wire tx_enable,
	output wire tx_data_a,
	output wire tx_data_b
);
	reg       en_r;
	reg       dat_r;
	reg [7:0] cnt_r;
	// enable leads; first edge is a fall one cycle later
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			en_r  <= 1'b0;
			dat_r <= 1'b1;
			cnt_r <= 8'h00;
		end else begin
			en_r <= run | hold;
			if (run && en_r) begin
				cnt_r <= (cnt_r == HALF - 1) ? 8'h00 : cnt_r + 8'h01;
				if (cnt_r == 8'h00)
					dat_r <= ~dat_r;
			end else if (!hold) begin
				cnt_r <= 8'h00;
				dat_r <= 1'b1;
			end
		end
	end
	// unused input tied high
	assign tx_enable = en_r;
	assign tx_data_a = use_b ? 1'b1 : dat_r;
	assign tx_data_b = use_b ? dat_r : 1'b1;
endmodule

// ===== bench/tb.sv
// self-checking bench for tpx_ctrl with a far-side transmit source
// assumes shortened timers; one oscillator tick is 25 clocks
`timescale 1ns/10ps
module tb;
	localparam HALF = 16;
	reg  clk;
	reg  resetn = 1'b0;
	reg  run = 1'b0;
	reg  hold = 1'b0;
	reg  use_b = 1'b0;
	reg  loopback_n = 1'b1;
	reg  full_duplex_select_n = 1'b1;
	reg  collision_selftest_n = 1'b1;
	reg  rx_unsquelched = 1'b0;
	reg  rx_line_data = 1'b1;
	reg  link_failed = 1'b0;
	reg  rx_out_ready = 1'b1;
	reg  rx_tog = 1'b0;
	wire tx_enable, tx_data_a, tx_data_b, rx_enable, rx_data_a, rx_data_b, tx_drive_en;
	wire tx_line_data, tx_preemph, link_fail_status, jabber_status;
	wire collision_or_jabber_status, osc_resync;
	int  err_total = 0;
	int  total_checks = 0;
	int  pe_cnt = 0;
	int  rt = 0;
	tpx_far #(.HALF(HALF)) far (.clk(clk), .resetn(resetn), .run(run), .hold(hold),
		.use_b(use_b), .tx_enable(tx_enable), .tx_data_a(tx_data_a), .tx_data_b(tx_data_b));
	tpx_ctrl #(.JAB_TICKS(50), .UNJAB_TICKS(80), .LINKINT_TICKS(40), .BLINK_TICKS(30)) DUT (
		.clk(clk), .resetn(resetn), .tx_data_a(tx_data_a), .tx_data_b(tx_data_b),
		.tx_enable(tx_enable), .loopback_n(loopback_n),
		.full_duplex_select_n(full_duplex_select_n), .collision_selftest_n(collision_selftest_n),
		.rx_unsquelched(rx_unsquelched), .rx_line_data(rx_line_data), .link_failed(link_failed),
		.rx_out_ready(rx_out_ready), .rx_enable(rx_enable), .rx_data_a(rx_data_a),
		.rx_data_b(rx_data_b), .tx_drive_en(tx_drive_en), .tx_line_data(tx_line_data),
		.tx_preemph(tx_preemph), .link_fail_status(link_fail_status),
		.jabber_status(jabber_status), .collision_or_jabber_status(collision_or_jabber_status),
		.osc_resync(osc_resync));
	// clock (reference for the 10 MHz tick), preemphasis tally, line toggler
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		rt <= rt + 1;
		if (tx_preemph === 1'b1)
			pe_cnt <= pe_cnt + 1;
		if (rx_tog && rt % HALF == 0)
			rx_line_data <= ~rx_line_data;
	end
	// ------
	// helpers
	// ------
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = rx_enable;
			1: pick = tx_drive_en;
			2: pick = osc_resync;
			3: pick = jabber_status;
			default: pick = collision_or_jabber_status;
		endcase
	endfunction
	// bounded wait for an output level; n is the cycles taken
	task automatic wait_for(input int s, input logic v, input int lim, output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (pick(s) !== v && n < lim);
		if (pick(s) !== v) begin
			err_total++;
			$display("Error wait on output %0d expected %b seen %b", s, v, pick(s));
			finish_test();
		end
	endtask
	// after a source edge let it settle, then compare rx and line data
	task automatic follow(input logic src, input logic tx);
		logic m;
		m = src ? rx_line_data : tx_data_a & tx_data_b;
		for (int i = 0; i < 40 && m === (src ? rx_line_data : tx_data_a & tx_data_b); i++)
			@(posedge clk);
		cyc(13);
		#1;
		m = src ? rx_line_data : tx_data_a & tx_data_b;
		chk("rx_data_a", m, rx_data_a);
		chk("rx_data_b", m, rx_data_b);
		if (tx)
			chk("tx_line_data", m, tx_line_data);
	endtask
	// ------
	// scenarios
	// ------
	task automatic s_idle;
		int n;
		cyc(1);
		#1;
		chk("rx_enable", 1'b0, rx_enable);
		chk("rx_data_a", 1'b1, rx_data_a);
		wait_for(1, 1'b1, 1100, n);
		wait_for(1, 1'b0, 60, n);
		chk("pulse width", n >= 24 && n <= 26, 1'b1);
		wait_for(1, 1'b1, 1100, n);
		chk("pulse gap", n >= 960 && n <= 1010, 1'b1);
	endtask
	task automatic s_tx;
		int n;
		int p;
		for (int b = 0; b < 2; b++) begin
			cyc(1);
			use_b <= b[0];
			run <= 1'b1;
			wait_for(2, 1'b1, 30, n);
			wait_for(1, 1'b1, 2, n);
			p = pe_cnt;
			cyc(8 * HALF);
			chk("preemph cycles", pe_cnt - p >= 84 && pe_cnt - p <= 108, 1'b1);
			follow(1'b0, 1'b1);
			chk("rx_enable", 1'b1, rx_enable);
			cyc(1);
			run <= 1'b0;
			wait_for(1, 1'b0, 200, n);
		end
	endtask
	task automatic s_full;
		cyc(1);
		full_duplex_select_n <= 1'b0;
		run <= 1'b1;
		cyc(100);
		#1;
		chk("rx_enable", 1'b0, rx_enable);
		chk("tx_drive_en", 1'b1, tx_drive_en);
		cyc(1);
		rx_unsquelched <= 1'b1;
		cyc(40);
		#1;
		chk("collision", 1'b0, collision_or_jabber_status);
		cyc(1);
		rx_unsquelched <= 1'b0;
		run <= 1'b0;
		full_duplex_select_n <= 1'b1;
		cyc(100);
	endtask
	task automatic s_loop;
		int p;
		cyc(1);
		loopback_n <= 1'b0;
		run <= 1'b1;
		cyc(20);
		p = pe_cnt;
		follow(1'b0, 1'b0);
		chk("rx_enable", 1'b1, rx_enable);
		chk("preemph", pe_cnt == p, 1'b1);
		cyc(1);
		run <= 1'b0;
		loopback_n <= 1'b1;
		cyc(100);
	endtask
	task automatic s_coll;
		int n;
		cyc(1);
		run <= 1'b1;
		cyc(50);
		rx_unsquelched <= 1'b1;
		wait_for(4, 1'b1, 40, n);
		chk("jabber", 1'b0, jabber_status);
		cyc(1);
		run <= 1'b0;
		rx_unsquelched <= 1'b0;
		wait_for(4, 1'b0, 1000, n);
	endtask
	task automatic s_sqe;
		int n;
		int p;
		cyc(1);
		collision_selftest_n <= 1'b0;
		wait_for(4, 1'b1, 30, n);
		p = pe_cnt;
		wait_for(4, 1'b0, 400, n);
		chk("selftest width", n >= 226 && n <= 250, 1'b1);
		chk("selftest line", pe_cnt == p, 1'b1);
		cyc(1);
		collision_selftest_n <= 1'b1;
	endtask
	task automatic s_jab;
		int n;
		for (int k = 0; k < 2; k++) begin
			cyc(1);
			run <= 1'b1;
			cyc(1400);
			#1;
			chk("jabber", 1'b1, jabber_status);
			chk("tx_drive_en", 1'b0, tx_drive_en);
			chk("collision", 1'b1, collision_or_jabber_status);
			cyc(1);
			hold <= k[0];
			run <= 1'b0;
			if (k == 1) begin
				cyc(1500);
				#1;
				chk("jabber kept", 1'b1, jabber_status);
			end
			wait_for(3, 1'b0, 700, n);
			if (k == 0)
				chk("unjab on enable", n < 60, 1'b1);
			cyc(1);
			hold <= 1'b0;
		end
	endtask
	task automatic s_rx;
		int n;
		logic m;
		cyc(1);
		rx_tog <= 1'b1;
		rx_unsquelched <= 1'b1;
		cyc(40);
		follow(1'b1, 1'b0);
		chk("rx_enable", 1'b1, rx_enable);
		cyc(1);
		rx_out_ready <= 1'b0;
		cyc(4);
		rx_out_ready <= 1'b1;
		follow(1'b1, 1'b0);
		m = link_fail_status;
		n = 0;
		repeat (1600) begin
			@(posedge clk);
			if (link_fail_status !== m)
				n++;
			m = link_fail_status;
		end
		chk("blink count", n >= 2 && n <= 3, 1'b1);
		rx_unsquelched <= 1'b0;
		rx_tog <= 1'b0;
		wait_for(0, 1'b0, 120, n);
		chk("rx_data_a", 1'b1, rx_data_a);
	endtask
	task automatic s_lnk;
		cyc(1);
		link_failed <= 1'b1;
		cyc(30);
		#1;
		chk("link_fail_status", 1'b1, link_fail_status);
		cyc(1);
		link_failed <= 1'b0;
		cyc(30);
		#1;
		chk("link_fail_status", 1'b0, link_fail_status);
	endtask
	// reset for 12 cycles, then the scenarios in turn
	initial begin
		cyc(12);
		resetn <= 1'b1;
		s_idle();
		s_tx();
		s_full();
		s_loop();
		s_coll();
		s_sqe();
		s_jab();
		s_rx();
		s_lnk();
		finish_test();
	end
endmodule
